// File: design/reset_strap_config_select.sv
// Purpose: strap capture and mode decode for boot and host interface
// Assumes: single 100 MHz clock standing in for the ring oscillator
// Notes: pin drivers for gpio/spi are shown as enables toward the pad ring
`timescale 1ns/1ns
module reset_strap_config_select
	import strap_cfg_pkg::*;
(
	// clock and reset
	input  wire logic        clk,
	input  wire logic        reset_pin_low,
	// part variant: 1 means internal eeprom part
	input  wire logic        int_eeprom_part,
	// multi-function strap pins, input side
	input  wire logic        test_gpio3_in,
	input  wire logic [2:0]  config_select_straps,
	input  wire logic        if1_miso_in,
	input  wire logic        if0_csn_in,
	// run-time pin roles
	output logic             gpio_mode,
	output logic             csn_out,
	output logic             csn_oe,
	output logic             miso_oe,
	// boot controller
	input  wire logic        boot_finish,
	output logic             boot_busy,
	output logic             boot_done_flag,
	input  wire logic        ring_osc_disable_bit,
	output logic             ring_osc_enable,
	// mode decisions
	output logic [5:0]       strap_status_reg,
	output logic             test_mode,
	output logic [2:0]       test_select,
	output logic             eeprom_prog_mode,
	output logic             skip_autocfg,
	output logic [2:0]       config_number,
	output logic             if_i2c,
	output logic             if_spi_slave,
	output logic             spi_master_boot,
	output logic             use_ext_eeprom,
	output logic             use_int_rom,
	// host register path
	input  wire logic        host_wr,
	input  wire logic        host_addr_sel,
	input  wire logic [6:0]  host_wdata,
	output logic             host_wr_taken,
	output logic [6:0]       slave_addr_reg,
	// identity
	output logic [15:0]      ident_reg_one,
	output logic [15:0]      ident_reg_two,
	// oscillator pins
	input  wire logic [1:0]  osc_pin_mode_field,
	output logic             xtal_drv_en,
	output logic             osc_pin_first_in_en,
	output logic             osc_pin_second_en
);

	// =====================================================
	// strap capture
	logic [5:0] strap_q;
	logic       strap_valid;

	// straps are taken at the first edge with reset_pin_low high; a sync reset cannot sample its own release
	strap_sampler u_samp (
		.clk         (clk),
		.reset_pin_low        (reset_pin_low), // RL15
		.strap_in    ({test_gpio3_in, config_select_straps, if1_miso_in, if0_csn_in}),
		.strap_q     (strap_q),
		.strap_valid (strap_valid)
	);

	logic       t_s;
	logic [2:0] ac_s;
	logic [1:0] if_s;

	assign t_s              = strap_q[ST_TEST];
	assign ac_s             = strap_q[ST_AC0 +: 3];
	assign if_s             = strap_q[ST_IF1:ST_IF0];
	assign strap_status_reg = strap_q; // RL1

	// true when the interface straps carry the spi code
	function automatic logic if_is_spi(input logic [1:0] code);
		return code == IFM_SPI;
	endfunction

	// =====================================================
	// mode decode
	assign test_mode        = strap_valid && t_s; // RL3
	assign test_select      = test_mode ? ac_s : 3'h0; // RL3
	assign eeprom_prog_mode = test_mode && int_eeprom_part && ac_s == TESTSEL_EEPROG && if_is_spi(if_s); // RL4
	assign skip_autocfg     = test_mode && ac_s == TESTSEL_NOAUTO; // RL5
	assign config_number    = ac_s; // RL6

	always_comb begin
		if_i2c          = 1'b0;
		if_spi_slave    = 1'b0;
		spi_master_boot = 1'b0;
		use_ext_eeprom  = 1'b0;
		use_int_rom     = 1'b0;
		if (strap_valid && !eeprom_prog_mode) begin
			if (int_eeprom_part) begin
				if_i2c       = !if_is_spi(if_s); // RL9
				if_spi_slave = if_is_spi(if_s); // RL9
			end else begin
				case (if_s)
					IFM_I2C0, IFM_I2C1: begin
						if_i2c      = 1'b1; // RL7
						use_int_rom = !skip_autocfg;
					end
					IFM_ALT: begin
						if_spi_slave = 1'b1; // RL8
						use_int_rom  = !skip_autocfg;
					end
					IFM_SPI: begin
						spi_master_boot = !skip_autocfg; // RL8
						use_ext_eeprom  = !skip_autocfg;
						if_spi_slave    = 1'b1;
					end
					default: begin
						if_i2c = 1'b0;
					end
				endcase
			end
		end
	end

	// =====================================================
	// boot controller
	boot_e state_r;
	boot_e state_nxt;

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			BOOT_IDLE: if (strap_valid) begin
				state_nxt = (skip_autocfg || eeprom_prog_mode) ? BOOT_DONE : BOOT_RUN;
			end
			BOOT_RUN: if (boot_finish) begin
				state_nxt = BOOT_DONE; // RL17
			end
			BOOT_DONE: state_nxt = BOOT_DONE;
			default: state_nxt = BOOT_IDLE;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!reset_pin_low) begin
			state_r <= BOOT_IDLE; // RL15
		end else begin
			state_r <= state_nxt;
		end
	end

	assign boot_busy       = state_r != BOOT_DONE; // RL16
	assign boot_done_flag  = state_r == BOOT_DONE; // RL17
	assign ring_osc_enable = !(boot_done_flag && ring_osc_disable_bit); // RL17

	// spi master boot owns the shared wires until boot done
	logic master_busy;
	assign master_busy = spi_master_boot && state_r != BOOT_DONE; // RL19

	// =====================================================
	// run-time pin roles
	assign gpio_mode = strap_valid; // RL2
	// csn is driven only while the master boot reads the external eeprom
	always_ff @(posedge clk) begin
		if (!reset_pin_low) begin
			csn_out <= 1'b1;
			csn_oe  <= 1'b0;
		end else begin
			csn_out <= !(spi_master_boot && state_r == BOOT_RUN); // RL11
			csn_oe  <= spi_master_boot && state_nxt == BOOT_RUN; // RL19
		end
	end
	assign miso_oe = strap_valid && if_spi_slave && !master_busy; // RL2 RL8

	// =====================================================
	// slave address register
	logic [6:0] def_addr;
	assign def_addr = {I2C_ADDR_PREFIX, if_s}; // RL7

	logic addr_set_r;
	logic [6:0] addr_r;

	assign host_wr_taken = host_wr && host_addr_sel && !master_busy; // RL19

	// a host write replaces the strap default until the next reset
	always_ff @(posedge clk) begin
		if (!reset_pin_low) begin
			addr_set_r <= 1'b0;
			addr_r     <= 7'h00;
		end else if (host_wr_taken) begin
			addr_set_r <= 1'b1; // RL10
			addr_r     <= host_wdata;
		end
	end
	assign slave_addr_reg = addr_set_r ? addr_r : def_addr; // RL10

	// =====================================================
	// identity and oscillator
	assign ident_reg_one       = {4'h0, DEVICE_ID_VAL}; // RL12
	assign ident_reg_two       = {12'h000, REVISION_VAL}; // RL12
	always_comb begin
		xtal_drv_en         = 1'b0;
		osc_pin_first_in_en = 1'b0;
		osc_pin_second_en   = 1'b0;
		case (osc_pin_mode_field)
			OSC_XTAL: begin
				xtal_drv_en         = 1'b1; // RL13
				osc_pin_first_in_en = 1'b1; // RL13
				osc_pin_second_en   = 1'b1; // RL13
			end
			OSC_CLKIN: begin
				osc_pin_first_in_en = 1'b1; // RL14
			end
			OSC_OFF: begin
				xtal_drv_en = 1'b0;
			end
			default: begin
				xtal_drv_en = 1'b0;
			end
		endcase
	end

endmodule

// File: design/strap_cfg_pkg.sv
// Purpose: constants for the reset strap configuration selector
// Assumes: 100 MHz clock, synchronous active-low reset
// Notes:
// Notes on behaviour
// (RL1) strap pin levels are captured at reset release into the strap status register
// (RL2) after reset the straps become gpio, chip select and data-out pins
// (RL3) test strap high enters test operation; config-select chooses the test mode
// (RL4) internal-eeprom part, test high, select 000, interface 11: eeprom programming mode
// (RL5) test high with select 011 starts normally but skips auto-configuration
// (RL6) config-select straps as a binary number choose configuration 0 to 7
// (RL7) rom part: interface 00/01 give i2c slave at 1110100/1110101 from internal rom
// (RL8) rom part: interface 10 spi slave from rom; 11 spi master reads external eeprom
// (RL9) internal-eeprom part: interface 00/01/10 give i2c addresses, 11 gives spi slave
// (RL10) strap i2c address is only a default; writable address register overrides it
// (RL11) external eeprom chip select follows ours during boot, idle during host access
// (RL12) 12-bit identity and 4-bit revision split over two identity registers
// (RL13) oscillator pin mode 01 enables the crystal driver across both pins
// (RL14) oscillator pin mode 10 makes the first pin a single-ended clock input
// (RL15) reset holds all logic at defaults while low; held low at least 1 us
// (RL16) boot controller runs from ring oscillator, independent of host interface
// (RL17) boot-done flag set when auto-configuration ends; ring oscillator may then stop
// (RL18) latched straps and derived modes hold until the next reset
// (RL19) host accesses ignored during spi master boot; chip select released at boot done
package strap_cfg_pkg;

	localparam logic [11:0] DEVICE_ID_VAL   = 12'h5a5; // arbitrary value
	localparam logic [3:0]  REVISION_VAL    = 4'h1;    // arbitrary value
	localparam logic [4:0]  I2C_ADDR_PREFIX = 5'h1d;
	localparam int          RESET_MIN_NS    = 1000;
	localparam int          CLK_PERIOD_NS   = 10;
	localparam int          RESET_MIN_CYC   = (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// strap status layout
	localparam int ST_IF0  = 0;
	localparam int ST_IF1  = 1;
	localparam int ST_AC0  = 2;
	localparam int ST_TEST = 5;
	localparam logic [5:0] STRAP_RST = 6'h00;

	// strap codes
	localparam logic [2:0] TESTSEL_EEPROG = 3'h0;
	localparam logic [2:0] TESTSEL_NOAUTO = 3'h3;
	localparam logic [1:0] IFM_I2C0    = 2'h0;
	localparam logic [1:0] IFM_I2C1    = 2'h1;
	localparam logic [1:0] IFM_ALT     = 2'h2;
	localparam logic [1:0] IFM_SPI     = 2'h3;

	// oscillator pin mode field
	localparam logic [1:0] OSC_OFF     = 2'h0;
	localparam logic [1:0] OSC_XTAL    = 2'h1;
	localparam logic [1:0] OSC_CLKIN   = 2'h2;

	typedef enum logic [1:0] {
		BOOT_IDLE = 2'b00,
		BOOT_RUN  = 2'b01,
		BOOT_DONE = 2'b11
	} boot_e;

endpackage

// File: design/strap_sampler.sv
// Purpose: captures the six straps once after reset release
// Assumes: straps synchronous to clk
// Notes: holds the value until the next reset
`timescale 1ns/1ns
module strap_sampler
	import strap_cfg_pkg::*;
(
	// clock and reset
	input  wire logic       clk,
	input  wire logic       reset_pin_low,
	// straps
	input  wire logic [5:0] strap_in,
	output logic      [5:0] strap_q,
	output logic            strap_valid
);

	logic taken_r;

	always_ff @(posedge clk) begin
		if (!reset_pin_low) begin
			taken_r <= 1'b0;
			strap_q <= STRAP_RST;
		end else if (!taken_r) begin
			taken_r <= 1'b1;
			strap_q <= strap_in; // RL1
		end
	end

	assign strap_valid = taken_r; // RL18

endmodule

// File: testbench/strap_board_model.sv
// Purpose: board straps and shared eeprom chip select
// Assumes: driven from the falling edge
// Notes: released pins show the inverse of the strap
`timescale 1ns/1ns
module strap_board_model (
	// clock and reset
	input  logic       clk,
	input  logic       reset_pin_low,
	// straps
	input  logic [5:0] lvl,
	output logic [5:0] pin,
	// chip select
	input  logic       csn_out,
	input  logic       csn_oe,
	output logic       eeprom_csn
);
	// ======== pins
	logic [1:0] cnt_r;
	always_ff @(negedge clk) cnt_r <= !reset_pin_low ? 2'h0 : cnt_r + {1'h0, cnt_r != 2'h2};
	assign pin = cnt_r == 2'h2 ? ~lvl : lvl;
	assign eeprom_csn = csn_oe ? csn_out : 1'h1;
endmodule

// File: testbench/strap_cfg_assertions.sv
// Purpose: port checks for strap capture and decode
// Assumes: sync active-low reset
// Notes: bound to the top module
`timescale 1ns/1ns
module strap_cfg_assertions (
	// clock and reset
	input logic       clk,
	input logic       reset_pin_low,
	// straps
	input logic       int_eeprom_part,
	input logic       test_gpio3_in,
	input logic [2:0] config_select_straps,
	input logic       if1_miso_in,
	input logic       if0_csn_in,
	// boot
	input logic       csn_oe,
	input logic       boot_finish,
	input logic       boot_busy,
	input logic       boot_done_flag,
	// decodes
	input logic [5:0] strap_status_reg,
	input logic       test_mode,
	input logic [2:0] config_number,
	input logic       gpio_mode,
	input logic       skip_autocfg,
	input logic       eeprom_prog_mode,
	input logic       spi_master_boot,
	// host and oscillator
	input logic       host_wr_taken,
	input logic [6:0] host_wdata,
	input logic [6:0] slave_addr_reg,
	input logic [1:0] osc_pin_mode_field,
	input logic       xtal_drv_en,
	input logic       osc_pin_first_in_en
);
	// ======== checks
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_pin_low);
	strap_capture_a: assert property (!$past(reset_pin_low) |=> strap_status_reg ==
		$past({test_gpio3_in, config_select_straps, if1_miso_in, if0_csn_in})) else $error("strap capture wrong");
	strap_hold_a: assert property (gpio_mode && $past(gpio_mode) |-> $stable(strap_status_reg))
		else $error("straps changed");
	config_decode_a: assert property (gpio_mode |-> config_number == strap_status_reg[4:2]
		&& test_mode == strap_status_reg[5]) else $error("config decode wrong");
	skip_decode_a: assert property (skip_autocfg == (strap_status_reg[5:2] == 4'hb))
		else $error("skip decode wrong");
	prog_decode_a: assert property (eeprom_prog_mode == (int_eeprom_part && strap_status_reg == 6'h23))
		else $error("prog decode wrong");
	host_refuse_a: assert property (spi_master_boot && boot_busy |-> !host_wr_taken)
		else $error("host write taken in boot");
	addr_write_a: assert property (host_wr_taken |=> slave_addr_reg == $past(host_wdata))
		else $error("address not written");
	boot_done_a: assert property (boot_busy && boot_finish |=> boot_done_flag ##1 !csn_oe)
		else $error("boot end wrong");
	osc_mode_a: assert property (xtal_drv_en == (osc_pin_mode_field == 2'h1)
		&& osc_pin_first_in_en == (osc_pin_mode_field inside {2'h1, 2'h2})) else $error("osc mode wrong");
endmodule
bind reset_strap_config_select strap_cfg_assertions u_chk (.*);

// File: testbench/tb_top.sv
// Purpose: self-checking bench for strap capture
// Assumes: straps from strap_board_model
// Notes: every strap code on both variants
`timescale 1ns/1ns
module tb_top import strap_cfg_pkg::*; ;
	logic clk = '0, reset_pin_low = '0, int_eeprom_part = '0, boot_finish = '0, ring_osc_disable_bit = '0;
	logic host_wr = '0, host_addr_sel = '0, v, e, m, dn, sl;
	logic [6:0] host_wdata = '0, slave_addr_reg;
	logic [1:0] osc_pin_mode_field = '0;
	logic [5:0] lvl = '0, s, pin, strap_status_reg;
	logic test_gpio3_in, if1_miso_in, if0_csn_in, eeprom_csn, gpio_mode, csn_out, csn_oe, miso_oe;
	logic [2:0] config_select_straps, test_select, config_number;
	logic boot_busy, boot_done_flag, ring_osc_enable, test_mode, eeprom_prog_mode, skip_autocfg, if_i2c;
	logic if_spi_slave, spi_master_boot, use_ext_eeprom, use_int_rom, host_wr_taken, xtal_drv_en;
	logic osc_pin_first_in_en, osc_pin_second_en;
	logic [15:0] ident_reg_one, ident_reg_two;
	int miscompares = 0, samples_checked = 0;
	assign {test_gpio3_in, config_select_straps, if1_miso_in, if0_csn_in} = pin;
	strap_board_model u_brd (.clk, .reset_pin_low, .lvl, .pin, .csn_out, .csn_oe, .eeprom_csn);
	reset_strap_config_select u_dut (.*);
	// ======== tasks
	task automatic chk(input string nm, input logic [15:0] x, input logic [15:0] g);
		samples_checked++;
		if (g !== x) begin
			$display("unexpected %s expected %h seen %h", nm, x, g);
			miscompares++;
		end
	endtask
	task automatic boot(input logic [5:0] st, input logic pv);
		@(negedge clk);
		reset_pin_low <= '0;
		lvl <= st;
		int_eeprom_part <= pv;
		repeat (100) @(negedge clk);
		reset_pin_low <= '1;
		repeat (4) @(negedge clk);
	endtask
	task finish_test;
		$display("checks %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	initial forever #5 clk = ~clk;
	initial begin
		#400000;
		miscompares++;
		finish_test();
	end
	initial begin
		repeat (6) @(negedge clk);
		reset_pin_low <= '1;
		// pins are inverted by now, so status also shows the hold
		for (int i = 0; i < 128; i++) begin
			s = i[5:0];
			v = i[6];
			e = v ? s[1:0] != 2'h3 : !s[1];
			m = !v && s[1:0] == 2'h3 && s[5:2] != 4'hb;
			dn = s[5:2] == 4'hb || v && s == 6'h23;
			sl = !(v && s == 6'h23) && (v ? s[1:0] == 2'h3 : s[1]);
			boot(s, v);
			chk("status", s, strap_status_reg);
			chk("gpio", 1, gpio_mode);
			chk("config", s[4:2], config_number);
			chk("test", s[5], test_mode);
			chk("skip", s[5:2] == 4'hb, skip_autocfg);
			chk("prog", v && s == 6'h23, eeprom_prog_mode);
			chk("i2c", e, if_i2c);
			if (e) chk("addr", {I2C_ADDR_PREFIX, s[1:0]}, slave_addr_reg);
			chk("master", m, spi_master_boot);
			chk("tsel", s[5] ? s[4:2] : 3'h0, test_select);
			chk("spis", sl, if_spi_slave);
			chk("rom", !v && s[1:0] != 2'h3 && s[5:2] != 4'hb, use_int_rom);
			chk("ext", m, use_ext_eeprom);
			chk("miso", sl && !m, miso_oe);
			chk("csnoe", m, csn_oe);
			chk("csn", !m, csn_out);
			chk("busy", !dn, boot_busy);
			chk("done", dn, boot_done_flag);
		end
		$display("test straps done");
		boot(6'h03, '0);
		chk("eecsn", 0, eeprom_csn);
		host_wr <= '1;
		host_addr_sel <= '1;
		host_wdata <= 7'h2a;
		@(negedge clk);
		chk("refuse", 0, host_wr_taken);
		host_wr <= '0;
		boot_finish <= '1;
		@(negedge clk);
		chk("addr", 7'h77, slave_addr_reg);
		boot_finish <= '0;
		repeat (2) @(negedge clk);
		chk("done", 1, boot_done_flag);
		chk("csnoe", 0, csn_oe);
		chk("eecsn", 1, eeprom_csn);
		chk("miso", 1, miso_oe);
		host_wr <= '1;
		ring_osc_disable_bit <= '1;
		@(negedge clk);
		chk("take", 1, host_wr_taken);
		host_wr <= '0;
		@(negedge clk);
		chk("addr", 7'h2a, slave_addr_reg);
		chk("ring", 0, ring_osc_enable);
		$display("test master boot done");
		for (int k = 0; k < 4; k++) begin
			osc_pin_mode_field <= k[1:0];
			@(negedge clk);
			chk("xtal", k == 1, xtal_drv_en);
			chk("xin", k == 1 || k == 2, osc_pin_first_in_en);
			chk("xb", k == 1, osc_pin_second_en);
		end
		chk("id", {4'h0, DEVICE_ID_VAL}, ident_reg_one);
		chk("rev", REVISION_VAL, ident_reg_two);
		$display("test osc and id done");
		finish_test();
	end
endmodule
